// ==== src/ssp_defines.vh ====
// register map, field positions, reset values and timing for the port pair
`ifndef SSP_DEFINES_VH
`define SSP_DEFINES_VH

// ****************************************************************
// register offsets within one port window
// ****************************************************************
`define SSP_OFS_CTRL    4'h0
`define SSP_OFS_DIV     4'h4
`define SSP_OFS_STAT    4'h8
`define SSP_OFS_SLOTS   4'hC
`define SSP_PORT_BIT    4
`define SSP_TOP_FREE    3'h0

// ****************************************************************
// control fields
// ****************************************************************
`define SSP_C_TXEN      0
`define SSP_C_RXEN      1
`define SSP_C_LSB       2
`define SSP_C_TCLK      3
`define SSP_C_TFS       4
`define SSP_C_RCLK      5
`define SSP_C_RFS       6
`define SSP_C_MCH       7
`define SSP_C_COMP_LO   8
`define SSP_C_WLEN_LO   10
`define SSP_C_FSINV     15
`define SSP_COMP_MU     2'h1
`define SSP_COMP_A      2'h2
`define SSP_WLEN_MIN    5'h02

// ****************************************************************
// status fields
// ****************************************************************
`define SSP_S_TXBUSY    0
`define SSP_S_TXFULL    1
`define SSP_S_RXBUSY    2
`define SSP_S_RXAVAIL   3
`define SSP_S_RXOVF     4
`define SSP_S_TXUND     5
`define SSP_S_CLAIM     6

// ****************************************************************
// reset values and bit rate limit
// ****************************************************************
`define SSP_CTRL_RST    32'h00007C00
`define SSP_SLOTS_RST   32'h00000000
`define SSP_CLK_MHZ     125
`define SSP_MAX_MBPS    40
`define SSP_DIV_MIN_INT ((`SSP_CLK_MHZ + 2 * `SSP_MAX_MBPS - 1) / (2 * `SSP_MAX_MBPS) - 1)
`define SSP_DIV_MIN     16'h0001
`define SSP_DIV_RST     {`SSP_DIV_MIN, `SSP_DIV_MIN}

`endif

// ==== src/ssp_fifo.v ====
// word fifo with registered output stage
`timescale 1ns/1ps
module ssp_fifo #(
  parameter W     = 32,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  input  wire         clk_i,
  input  wire         rst_i,
  input  wire         in_valid_i,
  output wire         in_ready_o,
  input  wire [W-1:0] in_data_i,
  output wire         out_valid_o,
  input  wire         out_ready_i,
  output wire [W-1:0] out_data_o
);
  localparam [AW:0] FULL = DEPTH;

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW-1:0] wp_reg;
  reg [AW-1:0] rp_reg;
  reg [AW:0]   cnt_reg;
  reg          ov_reg;
  reg [W-1:0]  od_reg;

  // depth must be a power of two so the pointers wrap by themselves
  wire push = in_valid_i & in_ready_o;
  wire load = (cnt_reg != {(AW+1){1'b0}}) & (~ov_reg | out_ready_i);

  assign in_ready_o  = (cnt_reg != FULL);
  assign out_valid_o = ov_reg;
  assign out_data_o  = od_reg;

  // storage array, no reset needed
  always @(posedge clk_i) begin
    if (push)
      mem[wp_reg] <= in_data_i;
  end

  // pointers, fill level and output stage
  always @(posedge clk_i) begin
    if (rst_i) begin
      wp_reg  <= {AW{1'b0}};
      rp_reg  <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
      ov_reg  <= 1'b0;
      od_reg  <= {W{1'b0}};
    end else begin
      if (push)
        wp_reg <= wp_reg + 1'b1;
      if (push & ~load)
        cnt_reg <= cnt_reg + 1'b1;
      else if (load & ~push)
        cnt_reg <= cnt_reg - 1'b1;
      if (load) begin
        od_reg <= mem[rp_reg];
        ov_reg <= 1'b1;
        rp_reg <= rp_reg + 1'b1;
      end else if (out_ready_i) begin
        ov_reg <= 1'b0;
      end
    end
  end
endmodule

// ==== src/ssp_top.v ====
// pair of synchronous serial ports with wishbone registers
//
// Behaviour
// - two identical independent serial ports
// - bit rate capped near processor rate, 40Mbps
// - transmit and receive timed separately
// - words stream to and from memory DMA
// - port 1 channels yield to link claim
// - multichannel mode: several slot words per frame
// - selectable lsb-first or msb-first order
// - word length programmable 3 to 32
// - frame sync polarity for external frame syncs only (generated syncs stay active high) and optional companding
// - clock and frame sync internal or external; transmit takes an external frame sync only with an external clock
//
// Our own choices: the register offsets and register access over Wishbone.
`timescale 1ns/1ps
`include "ssp_defines.vh"
module ssp_top #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire        wb_ack_o,
  input  wire [63:0] tx_data_i,
  input  wire [1:0]  tx_valid_i,
  output wire [1:0]  tx_ready_o,
  output wire [63:0] rx_data_o,
  output wire [1:0]  rx_valid_o,
  input  wire [1:0]  rx_ready_i,
  input  wire        link_claim_i,
  input  wire [1:0]  tclk_i,
  input  wire [1:0]  tfs_i,
  input  wire [1:0]  rclk_i,
  input  wire [1:0]  rfs_i,
  input  wire [1:0]  sdin_i,
  output wire [1:0]  tclk_o,
  output wire [1:0]  tclk_oe_o,
  output wire [1:0]  tfs_o,
  output wire [1:0]  tfs_oe_o,
  output wire [1:0]  sdout_o,
  output wire [1:0]  sdout_oe_o,
  output wire [1:0]  rclk_o,
  output wire [1:0]  rclk_oe_o,
  output wire [1:0]  rfs_o,
  output wire [1:0]  rfs_oe_o
);

  // ****************************************************************
  // helper functions
  // ****************************************************************

  // byte-lane merge for wishbone writes
  function [31:0] ssp_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer i;
    begin
      ssp_merge = old;
      for (i = 0; i < 4; i = i + 1)
        if (sel[i])
          ssp_merge[i*8 +: 8] = nw[i*8 +: 8];
    end
  endfunction

  // divider floor keeps the line at or under the top bit rate
  function [15:0] ssp_clamp;
    input [15:0] d;
    begin
      ssp_clamp = (d < `SSP_DIV_MIN) ? `SSP_DIV_MIN : d;
    end
  endfunction

  // 16-bit linear to 8-bit mu-law or a-law
  function [7:0] ssp_compress;
    input [15:0] x;
    input        alaw;
    reg [15:0] m;
    reg [15:0] t;
    reg [2:0]  seg;
    integer i;
    begin
      m   = x[15] ? (~x + 16'h0001) : x;
      seg = 3'h0;
      if (alaw) begin
        m = {3'h0, m[15:3]};
        for (i = 5; i < 12; i = i + 1)
          if (m >= (16'h0001 << i))
            seg = seg + 3'h1;
        t = (seg == 3'h0) ? {1'b0, m[15:1]} : (m >> seg);
        ssp_compress = {~x[15], seg, t[3:0]} ^ 8'h55;
      end else begin
        m = {2'h0, m[15:2]};
        if (m > 16'h1FDE)
          m = 16'h1FDE;       // clip before bias to avoid overflow
        m = m + 16'h0021;
        for (i = 6; i < 13; i = i + 1)
          if (m >= (16'h0001 << i))
            seg = seg + 3'h1;
        t = m >> ({1'b0, seg} + 4'h1); // 4 bits so segment 7 shifts by 8
        ssp_compress = ~{x[15], seg, t[3:0]};
      end
    end
  endfunction

  // 8-bit mu-law or a-law to 16-bit linear
  function [15:0] ssp_expand;
    input [7:0] code;
    input       alaw;
    reg [7:0]  c;
    reg [15:0] t;
    begin
      if (alaw) begin
        c = code ^ 8'h55;
        t = {8'h00, c[3:0], 4'h8};
        if (c[6:4] != 3'h0)
          t = t + 16'h0100;
        if (c[6:4] > 3'h1)
          t = t << (c[6:4] - 3'h1);
        ssp_expand = c[7] ? t : (~t + 16'h0001);
      end else begin
        c = ~code;
        t = ({12'h000, c[3:0]} << 3) + 16'h0084;
        t = (t << c[6:4]) - 16'h0084;
        ssp_expand = c[7] ? (~t + 16'h0001) : t;
      end
    end
  endfunction

  // ****************************************************************
  // pin synchronisers: three stages, change accepted when 2 and 3 agree
  // ****************************************************************
  wire [9:0] pin_w = {sdin_i, rfs_i, rclk_i, tfs_i, tclk_i};
  reg  [9:0] s1_reg;
  reg  [9:0] s2_reg;
  reg  [9:0] s3_reg;
  reg  [9:0] lvl_reg;
  wire [9:0] chg_w = ~(s2_reg ^ s3_reg) & (s2_reg ^ lvl_reg);

  // sync chain and filtered level
  always @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg  <= 10'h000;
      s2_reg  <= 10'h000;
      s3_reg  <= 10'h000;
      lvl_reg <= 10'h000;
    end else begin
      s1_reg  <= pin_w;
      s2_reg  <= s1_reg;
      s3_reg  <= s2_reg;
      lvl_reg <= lvl_reg ^ chg_w;
    end
  end

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  reg  [31:0] ctrl_reg  [0:1];
  reg  [31:0] div_reg   [0:1];
  reg  [31:0] slots_reg [0:1];
  wire [31:0] stat_w    [0:1];
  reg  [31:0] dat_reg;
  reg         ack_reg;
  wire        hit    = wb_cyc_i & wb_stb_i & ~ack_reg;
  wire        mapped = (wb_adr_i[7:5] == `SSP_TOP_FREE);
  wire        sel_p  = wb_adr_i[`SSP_PORT_BIT];
  wire        wr_w   = hit & wb_we_i & mapped;
  wire [1:0]  ovf_clr;
  wire [1:0]  und_clr;

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;

  // one-wait-state answer, unmapped reads return zero
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg      <= 1'b0;
      dat_reg      <= 32'h00000000;
      ctrl_reg[0]  <= `SSP_CTRL_RST;
      ctrl_reg[1]  <= `SSP_CTRL_RST;
      div_reg[0]   <= `SSP_DIV_RST;
      div_reg[1]   <= `SSP_DIV_RST;
      slots_reg[0] <= `SSP_SLOTS_RST;
      slots_reg[1] <= `SSP_SLOTS_RST;
    end else begin
      ack_reg <= hit;
      if (wr_w) begin
        case (wb_adr_i[3:0])
          `SSP_OFS_CTRL: begin
            ctrl_reg[sel_p] <= ssp_merge(ctrl_reg[sel_p], wb_dat_i, wb_sel_i);
          end
          `SSP_OFS_DIV: begin
            div_reg[sel_p] <= ssp_merge(div_reg[sel_p], wb_dat_i, wb_sel_i);
          end
          `SSP_OFS_SLOTS: begin
            slots_reg[sel_p] <= ssp_merge(slots_reg[sel_p], wb_dat_i,
                                          wb_sel_i) & 32'h0000001F;
          end
          default: begin
          end
        endcase
      end
      if (hit) begin
        case (wb_adr_i[3:0])
          `SSP_OFS_CTRL:  dat_reg <= mapped ? ctrl_reg[sel_p] : 32'h0;
          `SSP_OFS_DIV:   dat_reg <= mapped ? div_reg[sel_p] : 32'h0;
          `SSP_OFS_STAT:  dat_reg <= mapped ? stat_w[sel_p] : 32'h0;
          `SSP_OFS_SLOTS: dat_reg <= mapped ? slots_reg[sel_p] : 32'h0;
          default:        dat_reg <= 32'h00000000;
        endcase
      end
    end
  end

  // ****************************************************************
  // the two ports
  // ****************************************************************
  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1) begin : g_port
      wire [31:0] c      = ctrl_reg[p];
      wire        txen   = c[`SSP_C_TXEN];
      wire        rxen   = c[`SSP_C_RXEN];
      wire        lsb    = c[`SSP_C_LSB];
      wire        tcint  = c[`SSP_C_TCLK];
      wire        tfint  = c[`SSP_C_TFS];
      wire        rcint  = c[`SSP_C_RCLK];
      wire        rfint  = c[`SSP_C_RFS];
      wire        mch    = c[`SSP_C_MCH];
      wire [1:0]  comp   = c[`SSP_C_COMP_LO +: 2];
      wire        fsinv  = c[`SSP_C_FSINV];
      wire [4:0]  wraw   = c[`SSP_C_WLEN_LO +: 5];
      wire [4:0]  wl     = (wraw < `SSP_WLEN_MIN) ? `SSP_WLEN_MIN : wraw;
      wire [4:0]  nslot  = slots_reg[p][4:0];
      wire [15:0] tdiv   = ssp_clamp(div_reg[p][15:0]);
      wire [15:0] rdiv   = ssp_clamp(div_reg[p][31:16]);
      wire        gate   = (p == 1) ? link_claim_i : 1'b0;

      reg  [15:0] tcnt_reg;
      reg         tck_reg;
      reg  [15:0] rcnt_reg;
      reg         rck_reg;
      reg  [31:0] hold_reg;
      reg         hfull_reg;
      reg         trdy_reg;
      reg  [31:0] sh_reg;
      reg  [4:0]  tb_reg;
      reg  [4:0]  ts_reg;
      reg         tbusy_reg;
      reg         fpend_reg;
      reg         sd_reg;
      reg         sdoe_reg;
      reg         tfs_reg;
      reg         und_reg;
      reg         rfs_reg;
      reg         rbusy_reg;
      reg  [4:0]  rb_reg;
      reg  [4:0]  rs_reg;
      reg  [31:0] acc_reg;
      reg         push_reg;
      reg  [31:0] pd_reg;
      reg         ovf_reg;
      reg  [3:0]  oe_reg;
      wire        fin_rdy;

      // clock edges: own divider or filtered pin edges
      // a pin edge is the new level in stage two, not the old filtered one
      wire ttog   = txen & tcint & (tcnt_reg == tdiv);
      wire rtog   = rxen & rcint & (rcnt_reg == rdiv);
      wire t_rise = tcint ? (ttog & ~tck_reg) : (chg_w[p] & s2_reg[p]);
      wire r_rise = rcint ? (rtog & ~rck_reg) : (chg_w[4+p] & s2_reg[4+p]);
      wire r_fall = rcint ? (rtog & rck_reg) : (chg_w[4+p] & ~s2_reg[4+p]);
      wire t_fall = ~tcint & chg_w[p] & ~s2_reg[p];
      wire tfs_x  = lvl_reg[2+p] ^ fsinv;
      wire rfs_x  = rfint ? rfs_reg : (lvl_reg[6+p] ^ fsinv);
      wire rbit   = lvl_reg[8+p];
      wire tacc   = tx_valid_i[p] & trdy_reg;

      // next transmit word: companded from low half or taken whole
      wire [31:0] tword = (comp == `SSP_COMP_MU) ?
                          {24'h0, ssp_compress(hold_reg[15:0], 1'b0)} :
                          (comp == `SSP_COMP_A) ?
                          {24'h0, ssp_compress(hold_reg[15:0], 1'b1)} :
                          hold_reg;
      wire [31:0] tload = hfull_reg ? tword : 32'h0;
      wire        tfirst = lsb ? tload[0] : tload[wl];

      // receive assembly; first bit of a word clears the collector
      wire [31:0] abase = (rb_reg == 5'h00) ? 32'h0 : acc_reg;
      wire [31:0] anew  = lsb ? (abase | ({31'h0, rbit} << rb_reg)) :
                                {abase[30:0], rbit};
      wire [15:0] xpd   = ssp_expand(anew[7:0], comp == `SSP_COMP_A);
      wire [31:0] rword = (comp == 2'h0) ? anew : {{16{xpd[15]}}, xpd};

      // transmit and receive dividers run independently
      always @(posedge clk_i) begin
        if (rst_i | ~txen | ~tcint) begin
          tcnt_reg <= 16'h0000;
          tck_reg  <= 1'b0;
        end else if (ttog) begin
          tcnt_reg <= 16'h0000;
          tck_reg  <= ~tck_reg;
        end else begin
          tcnt_reg <= tcnt_reg + 16'h0001;
        end
        if (rst_i | ~rxen | ~rcint) begin
          rcnt_reg <= 16'h0000;
          rck_reg  <= 1'b0;
        end else if (rtog) begin
          rcnt_reg <= 16'h0000;
          rck_reg  <= ~rck_reg;
        end else begin
          rcnt_reg <= rcnt_reg + 16'h0001;
        end
      end

      // transmit: shift on rising edge, frame held until data is ready
      always @(posedge clk_i) begin
        if (rst_i) begin
          hold_reg  <= 32'h0;
          hfull_reg <= 1'b0;
          trdy_reg  <= 1'b0;
          sh_reg    <= 32'h0;
          tb_reg    <= 5'h00;
          ts_reg    <= 5'h00;
          tbusy_reg <= 1'b0;
          fpend_reg <= 1'b0;
          sd_reg    <= 1'b0;
          sdoe_reg  <= 1'b0;
          tfs_reg   <= 1'b0;
          und_reg   <= 1'b0;
        end else begin
          // conservative ready: never overlaps a full holding word
          trdy_reg <= ~hfull_reg & ~tacc & ~gate;
          if (tacc) begin
            hold_reg  <= tx_data_i[p*32 +: 32];
            hfull_reg <= 1'b1;
          end
          if (!txen) begin
            tbusy_reg <= 1'b0;
            sdoe_reg  <= 1'b0;
            tfs_reg   <= 1'b0;
            fpend_reg <= 1'b0;
          end else begin
            if (t_fall & ~tfint & tfs_x & ~tbusy_reg)
              fpend_reg <= 1'b1;
            if (t_rise) begin
              tfs_reg <= 1'b0;
              if (tbusy_reg & (tb_reg != wl)) begin
                sd_reg <= lsb ? sh_reg[1] : sh_reg[wl - 5'h01];
                sh_reg <= lsb ? (sh_reg >> 1) : (sh_reg << 1);
                tb_reg <= tb_reg + 5'h01;
              end else if (tbusy_reg & mch & (ts_reg != nslot)) begin
                // next slot of the frame; empty holding sends zeros
                sh_reg    <= tload;
                sd_reg    <= tfirst;
                tb_reg    <= 5'h00;
                ts_reg    <= ts_reg + 5'h01;
                hfull_reg <= 1'b0;
              end else if (hfull_reg & (tfint | fpend_reg)) begin
                sh_reg    <= tload;
                sd_reg    <= tfirst;
                tb_reg    <= 5'h00;
                ts_reg    <= 5'h00;
                tbusy_reg <= 1'b1;
                sdoe_reg  <= 1'b1;
                tfs_reg   <= tfint;
                fpend_reg <= 1'b0;
                hfull_reg <= 1'b0;
              end else begin
                tbusy_reg <= 1'b0;
                sdoe_reg  <= 1'b0;
              end
            end
          end
          // underflow set wins over a software clear
          und_reg <= (und_reg & ~und_clr[p]) |
                     (txen & t_rise & tbusy_reg & (tb_reg == wl) & mch &
                      (ts_reg != nslot) & ~hfull_reg);
        end
      end

      // receive: sample on falling edge, frame sync opens the word
      always @(posedge clk_i) begin
        if (rst_i) begin
          rfs_reg   <= 1'b0;
          rbusy_reg <= 1'b0;
          rb_reg    <= 5'h00;
          rs_reg    <= 5'h00;
          acc_reg   <= 32'h0;
          push_reg  <= 1'b0;
          pd_reg    <= 32'h0;
          ovf_reg   <= 1'b0;
          oe_reg    <= 4'h0;
        end else begin
          oe_reg   <= {rfint, rcint, tfint, tcint};
          push_reg <= 1'b0;
          if (!rxen) begin
            rfs_reg   <= 1'b0;
            rbusy_reg <= 1'b0;
            rb_reg    <= 5'h00;
            rs_reg    <= 5'h00;
          end else begin
            if (r_rise)
              rfs_reg <= rfint & ~rbusy_reg;
            if (r_fall & (rbusy_reg | rfs_x)) begin
              acc_reg <= anew;
              if (rb_reg == wl) begin
                push_reg <= 1'b1;
                pd_reg   <= rword;
                rb_reg   <= 5'h00;
                if (mch & (rs_reg != nslot)) begin
                  rs_reg    <= rs_reg + 5'h01;
                  rbusy_reg <= 1'b1;
                end else begin
                  rs_reg    <= 5'h00;
                  rbusy_reg <= 1'b0;
                end
              end else begin
                rb_reg    <= rb_reg + 5'h01;
                rbusy_reg <= 1'b1;
              end
            end
          end
          // a word that finds the fifo full is lost and flagged
          ovf_reg <= (ovf_reg & ~ovf_clr[p]) | (push_reg & ~fin_rdy);
        end
      end

      // receive words queue toward memory DMA
      ssp_fifo #(
        .W     (32),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
      ) u_rxq (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (push_reg),
        .in_ready_o  (fin_rdy),
        .in_data_i   (pd_reg),
        .out_valid_o (rx_valid_o[p]),
        .out_ready_i (rx_ready_i[p] & ~gate),
        .out_data_o  (rx_data_o[p*32 +: 32])
      );

      assign ovf_clr[p] = wr_w & (sel_p == p) &
                          (wb_adr_i[3:0] == `SSP_OFS_STAT) & wb_sel_i[0] &
                          wb_dat_i[`SSP_S_RXOVF];
      assign und_clr[p] = wr_w & (sel_p == p) &
                          (wb_adr_i[3:0] == `SSP_OFS_STAT) & wb_sel_i[0] &
                          wb_dat_i[`SSP_S_TXUND];
      assign stat_w[p]  = {25'h0, gate, und_reg, ovf_reg, rx_valid_o[p],
                           rbusy_reg, hfull_reg, tbusy_reg};
      assign tx_ready_o[p] = trdy_reg;
      assign tclk_o[p]     = tck_reg;
      assign rclk_o[p]     = rck_reg;
      assign tfs_o[p]      = tfs_reg;
      assign rfs_o[p]      = rfs_reg;
      assign sdout_o[p]    = sd_reg;
      assign sdout_oe_o[p] = sdoe_reg;
      assign tclk_oe_o[p]  = oe_reg[0];
      assign tfs_oe_o[p]   = oe_reg[1];
      assign rclk_oe_o[p]  = oe_reg[2];
      assign rfs_oe_o[p]   = oe_reg[3];
    end
  endgenerate
endmodule

// ==== verification/ssp_top_properties.sv ====
// concurrent checks on the port pair top level
`timescale 1ns/1ps
module ssp_top_properties (
  input wire        clk_i,
  input wire        rst_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire [1:0]  tx_valid_i,
  input wire [1:0]  tx_ready_o,
  input wire [63:0] rx_data_o,
  input wire [1:0]  rx_valid_o,
  input wire [1:0]  rx_ready_i,
  input wire        link_claim_i,
  input wire [1:0]  tclk_o,
  input wire [1:0]  tfs_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ****************************************************************
  // sequences
  // ****************************************************************
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_claim; link_claim_i [*2]; endsequence
  sequence s_stall; rx_valid_o[0] && !rx_ready_i[0]; endsequence
  // bus answer comes exactly one cycle after the request is taken
  a_ack_follows_req: assert property (s_req |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_tx_take_drop: assert property (
    tx_valid_i[0] && tx_ready_o[0] |=> !tx_ready_o[0])
    else $error("tx ready stayed high after transfer");
  // claim is seen one cycle late, so two cycles of it close the port
  a_tx1_claim_gate: assert property (s_claim |-> !tx_ready_o[1])
    else $error("port 1 tx ready during link claim");
  a_rx_valid_hold: assert property (s_stall |=> rx_valid_o[0])
    else $error("rx valid dropped while stalled");
  a_rx_data_hold: assert property (
    s_stall |=> $stable(rx_data_o[31:0]))
    else $error("rx data changed while stalled");
  // half period never below two clocks keeps the rate capped
  a_tclk_rate: assert property (
    $changed(tclk_o[0]) |=> $stable(tclk_o[0]))
    else $error("tx bit clock too fast");
  a_fs_at_clock: assert property ($rose(tfs_o[0]) |-> tclk_o[0])
    else $error("frame sync not with bit clock high");
endmodule

bind ssp_top ssp_top_properties u_props (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .tx_valid_i(tx_valid_i),
  .tx_ready_o(tx_ready_o), .rx_data_o(rx_data_o),
  .rx_valid_o(rx_valid_o), .rx_ready_i(rx_ready_i),
  .link_claim_i(link_claim_i), .tclk_o(tclk_o), .tfs_o(tfs_o)
);

// ==== verification/ssp_codec_model.sv ====
// serial codec model: captures tx words, sends rx words
`timescale 1ns/1ps
module ssp_codec_model (
  input  wire tclk_i,
  input  wire tfs_i,
  input  wire sd_i,
  output reg  rclk_o,
  output reg  rfs_o,
  output reg  sd_o
);
  reg [31:0] got;
  reg [31:0] sh_reg;
  integer    cnt;
  // link clock stands still outside frames
  initial begin
    rclk_o = 1'b0;
    rfs_o = 1'b0;
    sd_o = 1'b1;
    cnt = 99;
    got = 32'h0;
  end
  // sample on falling bit clock, word starts at frame sync
  always @(negedge tclk_i) begin
    if (tfs_i) begin
      cnt = 1;
      sh_reg = {31'h0, sd_i};
    end else if (cnt < 32) begin
      cnt = cnt + 1;
      sh_reg = {sh_reg[30:0], sd_i};
    end
    if (cnt == 8) got = sh_reg;
  end
  // drive on rising edge so data is settled at the falling edge
  task send(input [31:0] w, input integer n);
    integer i;
    begin
      for (i = n - 1; i >= 0; i = i - 1) begin
        rclk_o = 1'b1;
        rfs_o = (i == n - 1);
        sd_o = w[i];
        #32 rclk_o = 1'b0;
        #32;
      end
      rfs_o = 1'b0;
      sd_o = ~w[0]; // released line must not look held
    end
  endtask
endmodule

// ==== verification/ssp_top_test.sv ====
// self-checking bench for the serial port pair
`timescale 1ns/1ps
module ssp_top_test;
  reg         clk_i = 1'b0;
  reg         rst_i = 1'b1;
  reg         cyc = 1'b0;
  reg         we = 1'b0;
  reg  [7:0]  adr = 8'h00;
  reg  [31:0] wdat = 32'h0;
  reg  [31:0] rd;
  reg  [63:0] tx_data = 64'h0;
  reg  [1:0]  tx_valid = 2'h0;
  reg  [1:0]  rx_ready = 2'h0;
  reg         claim = 1'b0;
  wire [31:0] rdat;
  wire        ack;
  wire [1:0]  tx_ready, rx_valid, tclk, tfs, sdout, tclk_oe, rclk_oe;
  wire [63:0] rx_data;
  wire        c_rclk, c_rfs, c_sd;
  integer     miscompares = 0;
  integer     check_count = 0;
  integer     cycles = 0;
  integer     i;
  ssp_top dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_ready_i(rx_ready), .link_claim_i(claim),
    .tclk_i(2'h0), .tfs_i(2'h0), .rclk_i({1'b0, c_rclk}),
    .rfs_i({1'b0, c_rfs}), .sdin_i({1'b0, c_sd}), .tclk_o(tclk),
    .tclk_oe_o(tclk_oe), .tfs_o(tfs), .tfs_oe_o(), .sdout_o(sdout),
    .sdout_oe_o(), .rclk_o(), .rclk_oe_o(rclk_oe), .rfs_o(),
    .rfs_oe_o()
  );
  ssp_codec_model codec (
    .tclk_i(tclk[0]), .tfs_i(tfs[0]), .sd_i(sdout[0]),
    .rclk_o(c_rclk), .rfs_o(c_rfs), .sd_o(c_sd)
  );
  always #4 clk_i = ~clk_i;
  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares = miscompares + 1;
      print_verdict;
    end
  end
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // one classic cycle, held until ack is sampled
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      rd = rdat;
      cyc <= 1'b0;
      we <= 1'b0;
    end
  endtask
  task rdchk(input string name, input [7:0] a, input [31:0] exp);
    begin
      wb(1'b0, a, 32'h0);
      check(name, rd, exp);
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk("ctrl0", 8'h00, 32'h00007C00);
    rdchk("ctrl1", 8'h10, 32'h00007C00);
    rdchk("div0", 8'h04, 32'h00010001);
    rdchk("unmapped", 8'h20, 32'h0);
    wb(1'b1, 8'h1C, 32'h00000003);
    rdchk("slots1", 8'h1C, 32'h00000003);
    wb(1'b1, 8'h14, 32'h00050002);
    rdchk("div1", 8'h14, 32'h00050002);
    // 8-bit word, internal clock and sync, msb then lsb first
    for (i = 0; i < 2; i = i + 1) begin
      codec.got = 32'h0;
      wb(1'b1, 8'h00, 32'h00001C19 | (i << 2));
      @(posedge clk_i);
      tx_valid[0] <= 1'b1;
      tx_data[31:0] <= 32'h000000B4;
      @(posedge clk_i);
      while (tx_ready[0] !== 1'b1) @(posedge clk_i);
      tx_valid[0] <= 1'b0;
      while (codec.got === 32'h0) @(posedge clk_i);
      check("tx word", codec.got, i ? 32'h2D : 32'hB4);
    end
    check("clk oe int", {30'h0, tclk_oe[0], rclk_oe[0]}, 32'h2);
    // receive with clock and sync from the codec
    wb(1'b1, 8'h00, 32'h00001C02);
    #3 codec.send(32'h000000C6, 8);
    while (rx_valid[0] !== 1'b1) @(posedge clk_i);
    check("rx word", rx_data[31:0], 32'h000000C6);
    rx_ready[0] <= 1'b1;
    @(posedge clk_i);
    rx_ready[0] <= 1'b0;
    // mu-law code zero expands to the most negative linear step
    wb(1'b1, 8'h00, 32'h00001D02);
    #3 codec.send(32'h00000000, 8);
    while (rx_valid[0] !== 1'b1) @(posedge clk_i);
    check("rx mu", rx_data[31:0], 32'hFFFF8284);
    check("clk oe ext", {30'h0, tclk_oe[0], rclk_oe[0]}, 32'h0);
    claim <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("tx1 ready", {31'h0, tx_ready[1]}, 32'h0);
    wb(1'b0, 8'h18, 32'h0);
    check("claim bit", rd & 32'h40, 32'h40);
    claim <= 1'b0;
    repeat (3) @(posedge clk_i);
    check("tx1 free", {31'h0, tx_ready[1]}, 32'h1);
    print_verdict;
  end
endmodule
